/* idr_pkg.sv */
`default_nettype none
package idr_pkg;
    // ----------------------------------------
    // Sequence numbers (BCD as given by the caller)
    // ----------------------------------------
    localparam logic [15:0] SEQ_ASCII2 = 16'h0501;
    localparam logic [15:0] SEQ_ASCII4 = 16'h0502;
    localparam logic [15:0] SEQ_ASCII8 = 16'h0503;
    // ----------------------------------------
    // Per-sequence limits, index 0..2 = 501..503
    // ----------------------------------------
    localparam logic [3:0] MAX_HEADS [3] = '{4'h2, 4'h4, 4'h8};
    localparam logic [5:0] MIN_SEND_WORDS = 6'h06;
    localparam logic [5:0] MAX_SEND_WORDS [3] = '{6'h0a, 6'h12, 6'h22};
    localparam logic [7:0] MAX_LEN [3] = '{8'h76, 8'h30, 8'h14};
    localparam logic [7:0] REGION_WORDS [3] = '{8'h3c, 8'h18, 8'h0a};
    // ----------------------------------------
    // Send word layout
    // ----------------------------------------
    localparam logic [5:0] OFS_SEND_COUNT = 6'h00;
    localparam logic [5:0] OFS_HEADS = 6'h01;
    localparam logic [5:0] OFS_FIRST_GROUP = 6'h02;
    localparam logic [1:0] GRP_UNIT = 2'h0;
    localparam logic [1:0] GRP_CHAN = 2'h1;
    localparam logic [1:0] GRP_ADDR = 2'h2;
    localparam logic [1:0] GRP_LEN = 2'h3;
    localparam logic [3:0] CHAN_FIRST = 4'h1;
    localparam logic [3:0] CHAN_SECOND = 4'h2;
    // ----------------------------------------
    // Receive word layout
    // ----------------------------------------
    localparam logic [7:0] OFS_RECV_COUNT = 8'h00;
    localparam logic [7:0] OFS_RECV_DATA = 8'h01;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_WAIT = 3'b010,
        S_LATCH = 3'b011,
        S_CMD = 3'b100,
        S_DATA = 3'b101,
        S_COUNT = 3'b110
    } idr_state_t;
endpackage
`default_nettype wire

/* idr_fifo.sv */
`default_nettype none
module idr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Synchronous reset
    input wire logic in_valid, // Write request
    output logic in_ready, // Space available (registered)
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Data available (registered)
    input wire logic out_ready, // Consumer takes a word
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_d;
            // Flags kept as flops so the ready pin is a clean register
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
            out_valid <= (cnt_d != '0);
        end
    end
endmodule // idr_fifo
`default_nettype wire

/* idr_top.sv */
`default_nettype none
module idr_top (
    input wire logic CLK, // 40 MHz clock
    input wire logic RST_N, // Synchronous reset, active low
    input wire logic START, // Pulse: run the sequence in SEQ_NO
    input wire logic [15:0] SEQ_NO, // BCD sequence number
    output logic BUSY, // Sequence in progress
    output logic DONE, // Pulse: sequence finished
    output logic ERR, // Pulse with DONE: request refused
    output logic SEND_RD, // Pulse: read send word
    output logic [5:0] SEND_ADDR, // Send word offset
    input wire logic [15:0] SEND_DATA, // Send word, cycle after SEND_RD
    output logic CMD_VALID, // Carrier read command pending
    input wire logic CMD_READY, // Link takes the command
    output logic [7:0] CMD_UNIT, // Unit number, BCD
    output logic [3:0] CMD_CHAN, // head_channel_select
    output logic [15:0] CMD_ADDR, // Leading carrier address
    output logic [7:0] CMD_LEN, // Bytes to read
    input wire logic RX_VALID, // Read byte offered
    output logic RX_READY, // FIFO has room
    input wire logic [7:0] RX_BYTE, // ASCII byte from carrier
    output logic RECV_WE, // Pulse: write receive word
    output logic [7:0] RECV_ADDR, // Receive word offset
    output logic [15:0] RECV_DATA // Receive word
);
    import idr_pkg::*;

    idr_state_t state_q;
    logic [1:0] sel_q;
    logic check_q;
    logic [5:0] w_q;
    logic [6:0] words_q;
    logic [3:0] heads_q;
    logic [2:0] h_q;
    logic [7:0] b_q;
    logic [7:0] hi_q;
    logic [7:0] last_q;
    logic bad;
    logic f_valid;
    logic f_ready;
    logic [7:0] f_data;
    logic [1:0] gw;
    logic [7:0] base;
    logic [7:0] waddr;

    function automatic logic bcd_ok(input logic [15:0] v);
        bcd_ok = v[3:0] < 4'ha && v[7:4] < 4'ha && v[11:8] == 4'h0
                 && v[15:12] == 4'h0;
    endfunction

    function automatic logic [15:0] to_bcd(input logic [7:0] v);
        logic [7:0] r;
        logic [3:0] hd;
        logic [3:0] td;
        r = v;
        hd = 4'h0;
        td = 4'h0;
        if (r >= 8'd100) begin
            r = r - 8'd100;
            hd = 4'h1;
        end
        while (r >= 8'd10) begin
            r = r - 8'd10;
            td = td + 4'h1;
        end
        to_bcd = {4'h0, hd, td, r[3:0]};
    endfunction

    // -------------------------------------------------
    // Read byte buffer
    // -------------------------------------------------
    idr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(RX_VALID),
        .in_ready(RX_READY),
        .in_data(RX_BYTE),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign f_ready = (state_q == S_DATA) && !RECV_WE;
    assign gw = 2'(w_q - OFS_FIRST_GROUP);
    assign base = 8'(REGION_WORDS[sel_q] * h_q);
    assign waddr = OFS_RECV_DATA + base + {1'b0, b_q[7:1]};

    // Field checks on the word now returned by the controller
    always_comb begin
        bad = 1'b0;
        if (w_q == OFS_SEND_COUNT) begin
            bad = !bcd_ok(SEND_DATA);
        end else if (w_q == OFS_HEADS) begin
            bad = !bcd_ok(SEND_DATA) || SEND_DATA[7:4] != 4'h0
                  || SEND_DATA[3:0] == 4'h0
                  || SEND_DATA[3:0] > MAX_HEADS[sel_q]
                  || words_q < {1'b0, MIN_SEND_WORDS}
                  || words_q > {1'b0, MAX_SEND_WORDS[sel_q]};
        end else begin
            case (gw)
                GRP_UNIT: bad = SEND_DATA[3:0] > 4'h9 || SEND_DATA[7:4] > 4'h9;
                GRP_CHAN: bad = SEND_DATA[3:0] != CHAN_FIRST
                                && SEND_DATA[3:0] != CHAN_SECOND;
                GRP_ADDR: bad = 1'b0;
                GRP_LEN: bad = SEND_DATA[7:0] == 8'h00
                               || SEND_DATA[7:0] > MAX_LEN[sel_q];
                default: bad = 1'b1;
            endcase
        end
    end

    // -------------------------------------------------
    // Sequencer
    // -------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            sel_q <= 2'h0;
            check_q <= 1'b0;
            w_q <= 6'h00;
            words_q <= 7'h00;
            heads_q <= 4'h0;
            h_q <= 3'h0;
            b_q <= 8'h00;
            hi_q <= 8'h00;
            last_q <= 8'h00;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            ERR <= 1'b0;
            SEND_RD <= 1'b0;
            SEND_ADDR <= 6'h00;
            CMD_VALID <= 1'b0;
            CMD_UNIT <= 8'h00;
            CMD_CHAN <= 4'h0;
            CMD_ADDR <= 16'h0000;
            CMD_LEN <= 8'h00;
            RECV_WE <= 1'b0;
            RECV_ADDR <= 8'h00;
            RECV_DATA <= 16'h0000;
        end else begin
            DONE <= 1'b0;
            ERR <= 1'b0;
            SEND_RD <= 1'b0;
            RECV_WE <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (START) begin
                        if (SEQ_NO == SEQ_ASCII2 || SEQ_NO == SEQ_ASCII4
                            || SEQ_NO == SEQ_ASCII8) begin
                            sel_q <= 2'(SEQ_NO[3:0] - 4'h1);
                            check_q <= 1'b1;
                            w_q <= OFS_SEND_COUNT;
                            h_q <= 3'h0;
                            BUSY <= 1'b1;
                            state_q <= S_FETCH;
                        end else begin
                            DONE <= 1'b1;
                            ERR <= 1'b1;
                        end
                    end
                end
                S_FETCH: begin
                    SEND_RD <= 1'b1;
                    SEND_ADDR <= w_q;
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    state_q <= S_LATCH;
                end
                S_LATCH: begin
                    state_q <= S_FETCH;
                    w_q <= w_q + 6'h01;
                    if (check_q && bad) begin
                        // Whole request is checked before any carrier read
                        BUSY <= 1'b0;
                        DONE <= 1'b1;
                        ERR <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (w_q == OFS_SEND_COUNT) begin
                        // Seven bits so that counts up to 99 cannot wrap
                        // into the legal range
                        words_q <= 7'(SEND_DATA[7:4] * 4'ha)
                                   + 7'(SEND_DATA[3:0]);
                    end else if (w_q == OFS_HEADS) begin
                        heads_q <= SEND_DATA[3:0];
                    end else begin
                        case (gw)
                            GRP_UNIT: CMD_UNIT <= SEND_DATA[7:0];
                            GRP_CHAN: CMD_CHAN <= SEND_DATA[3:0];
                            GRP_ADDR: CMD_ADDR <= SEND_DATA;
                            default: CMD_LEN <= SEND_DATA[7:0];
                        endcase
                        if (gw == GRP_LEN) begin
                            if (!check_q) begin
                                CMD_VALID <= 1'b1;
                                state_q <= S_CMD;
                            end else if (w_q[5:2] == heads_q) begin
                                // Checks passed; walk the groups again
                                check_q <= 1'b0;
                                w_q <= OFS_FIRST_GROUP;
                            end
                        end
                    end
                end
                S_CMD: begin
                    if (CMD_READY) begin
                        CMD_VALID <= 1'b0;
                        b_q <= 8'h00;
                        state_q <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (f_valid && f_ready) begin
                        b_q <= b_q + 8'h01;
                        if (!b_q[0]) begin
                            hi_q <= f_data;
                        end
                        // Two bytes per word, first byte high; odd tail pads
                        if (b_q[0] || b_q + 8'h01 == CMD_LEN) begin
                            RECV_WE <= 1'b1;
                            RECV_ADDR <= waddr;
                            RECV_DATA <= b_q[0] ? {hi_q, f_data}
                                                : {f_data, PAD_BYTE};
                            last_q <= waddr;
                        end
                        if (b_q + 8'h01 == CMD_LEN) begin
                            if ({1'b0, h_q} + 4'h1 == heads_q) begin
                                state_q <= S_COUNT;
                            end else begin
                                h_q <= h_q + 3'h1;
                                state_q <= S_FETCH;
                            end
                        end
                    end
                end
                S_COUNT: begin
                    if (!RECV_WE) begin
                        RECV_WE <= 1'b1;
                        RECV_ADDR <= OFS_RECV_COUNT;
                        RECV_DATA <= to_bcd(last_q + 8'h01);
                        BUSY <= 1'b0;
                        DONE <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule // idr_top
`default_nettype wire

/* idr_link_model.sv */
`default_nettype none
module idr_link_model (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic cmd_valid, // Read command pending
    output logic cmd_ready, // Command taken
    input wire logic [15:0] cmd_addr, // Leading carrier address
    input wire logic [7:0] cmd_len, // Bytes to return
    output logic rx_valid, // Byte offered
    input wire logic rx_ready, // Byte taken at this edge
    output logic [7:0] rx_byte // ASCII byte
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    int idx = 0;
    int gap = 0;
    logic [15:0] base = 16'h0000;
    // Random gaps let the four-byte buffer fill and also run dry
    always @(posedge clk) begin
        cmd_ready <= 1'b0;
        if (!rst_n) begin
            rx_valid <= 1'b0;
            rx_byte <= 8'h5a;
            left = 0;
            gap = 0;
            idx = 0;
        end else if (rx_valid) begin
            if (rx_ready) begin
                left--;
                idx++;
                gap = $urandom_range(3);
                if (gap == 0 && left > 0) begin
                    rx_byte <= 8'h21 + 8'((int'(base) + idx) % 94);
                end else begin
                    // A released line shows the inverse, never a stale byte
                    rx_valid <= 1'b0;
                    rx_byte <= ~rx_byte;
                end
            end
        end else if (gap > 0) begin
            gap--;
        end else if (left > 0) begin
            rx_valid <= 1'b1;
            rx_byte <= 8'h21 + 8'((int'(base) + idx) % 94);
        end else if (cmd_valid && !cmd_ready) begin
            cmd_ready <= 1'b1;
            base = cmd_addr;
            left = int'(cmd_len);
            idx = 0;
        end
    end
endmodule // idr_link_model
`default_nettype wire

/* idr_top_props.sv */
`default_nettype none
module idr_top_props (
    input wire logic CLK, // Clock
    input wire logic RST_N, // Reset, active low
    input wire logic START, // Start pulse
    input wire logic [15:0] SEQ_NO, // Sequence number
    input wire logic BUSY, // Busy level
    input wire logic DONE, // Done pulse
    input wire logic ERR, // Refusal pulse
    input wire logic SEND_RD, // Send word read
    input wire logic CMD_VALID, // Command pending
    input wire logic CMD_READY, // Command taken
    input wire logic [3:0] CMD_CHAN, // Channel
    input wire logic [15:0] CMD_ADDR, // Address
    input wire logic [7:0] CMD_LEN, // Byte count
    input wire logic RECV_WE, // Receive write
    input wire logic [7:0] RECV_ADDR // Receive offset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    logic cmd_seen_q;
    always_ff @(posedge CLK) begin
        if (!RST_N || (START && !BUSY)) cmd_seen_q <= 1'b0;
        else if (CMD_VALID) cmd_seen_q <= 1'b1;
    end
    a_refuse_no_cmd: assert property (ERR |-> !cmd_seen_q && !CMD_VALID)
        else $error("command issued before refusal");
    a_bad_seq: assert property (START && !BUSY &&
        !(SEQ_NO inside {16'h0501, 16'h0502, 16'h0503}) |=> DONE && ERR)
        else $error("unknown sequence not refused");
    a_err_with_done: assert property (ERR |-> DONE)
        else $error("ERR without DONE");
    a_done_ends: assert property (DONE |=> !DONE && !BUSY)
        else $error("DONE not a single closing pulse");
    a_busy_cause: assert property ($rose(BUSY) |-> $past(START))
        else $error("BUSY rose without START");
    a_cmd_hold: assert property (CMD_VALID && !CMD_READY |=> CMD_VALID &&
        $stable(CMD_ADDR) && $stable(CMD_LEN) && $stable(CMD_CHAN))
        else $error("command changed before accept");
    a_cmd_fields: assert property (CMD_VALID |->
        CMD_LEN inside {[8'h01:8'h76]} && CMD_CHAN inside {4'h1, 4'h2})
        else $error("command field out of range");
    a_count_last: assert property (RECV_WE && RECV_ADDR == 8'h00 |->
        DONE && !ERR)
        else $error("count word not written with DONE");
    a_send_cadence: assert property (SEND_RD |=> !SEND_RD [*2])
        else $error("send reads closer than three cycles");
endmodule // idr_top_props
bind idr_top idr_top_props u_props (.CLK(CLK), .RST_N(RST_N),
    .START(START), .SEQ_NO(SEQ_NO), .BUSY(BUSY), .DONE(DONE), .ERR(ERR),
    .SEND_RD(SEND_RD), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD_CHAN(CMD_CHAN), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN),
    .RECV_WE(RECV_WE), .RECV_ADDR(RECV_ADDR));
`default_nettype wire

/* test_id_carrier_multi_head_ascii_read.sv */
`default_nettype none
module test_id_carrier_multi_head_ascii_read;
    timeunit 1ns;
    timeprecision 1ps;
    import idr_pkg::*;
    logic CLK, RST_N, START, BUSY, DONE, ERR, SEND_RD, CMD_VALID, CMD_READY;
    logic RX_VALID, RX_READY, RECV_WE, err;
    logic [15:0] SEQ_NO, SEND_DATA, CMD_ADDR, RECV_DATA, seq;
    logic [5:0] SEND_ADDR;
    logic [7:0] CMD_UNIT, CMD_LEN, RX_BYTE, RECV_ADDR;
    logic [3:0] CMD_CHAN;
    logic [15:0] send_mem [64];
    logic [15:0] recv_mem [256];
    logic [15:0] addrs [8];
    logic [35:0] expq [$];
    logic [35:0] cmdq [$];
    int lens [8];
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int dones = 0;
    int s, h, rw, d0;
    idr_top DUT (.CLK(CLK), .RST_N(RST_N), .START(START), .SEQ_NO(SEQ_NO),
        .BUSY(BUSY), .DONE(DONE), .ERR(ERR), .SEND_RD(SEND_RD),
        .SEND_ADDR(SEND_ADDR), .SEND_DATA(SEND_DATA),
        .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_UNIT(CMD_UNIT),
        .CMD_CHAN(CMD_CHAN), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN),
        .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_BYTE(RX_BYTE),
        .RECV_WE(RECV_WE), .RECV_ADDR(RECV_ADDR), .RECV_DATA(RECV_DATA));
    idr_link_model link (.clk(CLK), .rst_n(RST_N), .cmd_valid(CMD_VALID),
        .cmd_ready(CMD_READY), .cmd_addr(CMD_ADDR), .cmd_len(CMD_LEN),
        .rx_valid(RX_VALID), .rx_ready(RX_READY), .rx_byte(RX_BYTE));
    function automatic logic [15:0] bcd(int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    function automatic logic [7:0] chr(logic [15:0] a, int i);
        return 8'h21 + 8'((int'(a) + i) % 94);
    endfunction
    task automatic chk(string what, logic [35:0] exp, logic [35:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------
    // Caller's send words and the receive area
    // ----------------------------------------
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles++;
        if (!RST_N) SEND_DATA <= 16'h0000;
        else SEND_DATA <= SEND_RD ? send_mem[SEND_ADDR] : ~SEND_DATA;
        if (RECV_WE) recv_mem[RECV_ADDR] = RECV_DATA;
        if (CMD_VALID && CMD_READY)
            cmdq.push_back({CMD_UNIT, CMD_CHAN, CMD_ADDR, CMD_LEN});
        if (DONE) dones++;
        if (cycles > 30000) begin
            failures++;
            summarize();
        end
    end
    task automatic build(int si, int hn);
        logic [7:0] u;
        logic [3:0] c;
        expq.delete();
        cmdq.delete();
        for (int i = 0; i < 64; i++) send_mem[i] = 16'($urandom);
        send_mem[0] = bcd(2 + 4 * hn);
        send_mem[1] = bcd(hn);
        for (int n = 0; n < hn; n++) begin
            u = {4'($urandom_range(9)), 4'($urandom_range(9))};
            c = 4'($urandom_range(2, 1));
            addrs[n] = 16'($urandom);
            lens[n] = n == 0 ? int'(MAX_LEN[si]) :
                $urandom_range(int'(MAX_LEN[si]), 1);
            send_mem[4 * n + 2][7:0] = u;
            send_mem[4 * n + 3][3:0] = c;
            send_mem[4 * n + 4] = addrs[n];
            send_mem[4 * n + 5][7:0] = 8'(lens[n]);
            expq.push_back({u, c, addrs[n], 8'(lens[n])});
        end
    endtask
    task automatic go(logic [15:0] sq, bit again);
        int n = 0;
        START <= 1'b1;
        SEQ_NO <= sq;
        @(posedge CLK);
        START <= 1'b0;
        if (again) begin
            // A second start while busy must be ignored
            repeat (6) @(posedge CLK);
            START <= 1'b1;
            @(posedge CLK);
            START <= 1'b0;
        end
        while (DONE !== 1'b1 && n < 20000) begin
            @(posedge CLK);
            n++;
        end
        err = ERR;
        repeat (3) @(posedge CLK);
    endtask
    initial begin
        RST_N = 1'b0;
        START = 1'b0;
        SEQ_NO = 16'h0000;
        void'($urandom(32'h2434));
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        for (s = 0; s < 3; s++) for (int r = 0; r < 2; r++) begin
            h = r ? int'(MAX_HEADS[s]) : 1;
            rw = int'(REGION_WORDS[s]);
            build(s, h);
            recv_mem = '{default: 16'hdead};
            d0 = dones;
            go(SEQ_ASCII2 + 16'(s), r == 1);
            chk("refused", 36'h0, 36'(err));
            chk("done count", 36'h1, 36'(dones - d0));
            for (int n = 0; n < h; n++) begin
                chk("command", expq.pop_front(), cmdq.pop_front());
                for (int k = 0; k < (lens[n] + 1) / 2; k++)
                    chk("read word", {20'h0, chr(addrs[n], 2 * k),
                        2 * k + 1 < lens[n] ? chr(addrs[n], 2 * k + 1) : 8'h00},
                        36'(recv_mem[1 + rw * n + k]));
            end
            chk("count word", 36'(bcd(rw * (h - 1) + (lens[h - 1] + 1) / 2 + 1)),
                36'(recv_mem[0]));
        end
        for (int c = 0; c < 9; c++) begin
            s = c % 3;
            build(s, 1);
            seq = SEQ_ASCII2 + 16'(s);
            case (c)
                0: seq = 16'h0504;
                1: send_mem[1] = 16'h0000;
                2: send_mem[1] = bcd(int'(MAX_HEADS[s]) + 1);
                3: send_mem[0] = 16'h0005;
                4: send_mem[0] = bcd(int'(MAX_SEND_WORDS[s]) + 1);
                5: send_mem[3][3:0] = 4'h3;
                6: send_mem[5][7:0] = 8'h00;
                7: send_mem[5][7:0] = MAX_LEN[s] + 8'h01;
                // Valid BCD far above every limit
                default: send_mem[0] = 16'h0070;
            endcase
            go(seq, 1'b0);
            chk("refused", 36'h1, 36'(err));
            chk("commands", 36'h0, 36'(cmdq.size()));
        end
        summarize();
    end
endmodule // test_id_carrier_multi_head_ascii_read
`default_nettype wire
